// ---- nbr_sequencer.sv ----
// nvm burn and reload sequencer with its register window
`timescale 1ns/1ps
`include "nbr_defs.svh"
module nbr_sequencer #(
   parameter int          LABEL_BYTES   = 8,
   parameter int          PROG_CYCLES   = 64,
   parameter logic [63:0] FACTORY_IMAGE = 64'h0000000000000000
) (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst_b,
   input  wire logic                  i_reset_pin_n,
   input  wire nbr_pkg::nbr_reg_req_t i_reg_req,
   output      logic [7:0]            o_reg_rdata,
   output      logic                  o_reg_rvalid,
   output      logic                  o_busy
);

   localparam int AW = $clog2(LABEL_BYTES);
   localparam int CW = $clog2(PROG_CYCLES + 1);

   // ==========================================================
   // state
   nbr_pkg::nbr_state_t state_q;
   nbr_pkg::nbr_state_t state_d;
   logic [AW-1:0]       idx_q;
   logic [AW-1:0]       idx_d;
   logic [CW-1:0]       prog_cnt_q;
   logic [CW-1:0]       prog_cnt_d;
   logic [1:0]          burned_q;
   logic [1:0]          burned_d;
   logic [1:0]          active_q;
   logic [1:0]          active_d;
   logic [7:0]          label_q [LABEL_BYTES];
   logic [7:0]          rdata_d;

   // ==========================================================
   // address decode
   wire        idle       = (state_q == nbr_pkg::NBR_IDLE);
   wire [15:0] lbl_off    = i_reg_req.addr - `NBR_ADDR_LBL_FIRST;
   wire        hit_lbl    = (i_reg_req.addr >= `NBR_ADDR_LBL_FIRST) && (i_reg_req.addr <= `NBR_ADDR_LBL_LAST);
   wire [AW-1:0] lbl_idx  = lbl_off[AW-1:0];
   wire        hit_ready  = (i_reg_req.addr[7:0] == `NBR_READY_OFFSET);
   wire        hit_bank   = (i_reg_req.addr == `NBR_ADDR_BANK);
   // writes other than the full reset are only honoured while idle; a host that
   // ignores the ready code could otherwise tear the image mid-copy
   wire        wr_ok      = i_reg_req.wr && idle;
   wire        burn_cmd   = wr_ok && (i_reg_req.addr == `NBR_ADDR_BURN)
                            && (i_reg_req.wdata == `NBR_BURN_KEY);
   wire        burn_go    = burn_cmd && (burned_q != `NBR_USER_BANKS);
   wire        reload_cmd = wr_ok && (i_reg_req.addr == `NBR_ADDR_RELOAD)
                            && i_reg_req.wdata[`NBR_RELOAD_BIT];
   wire        full_rst   = i_reg_req.wr && (i_reg_req.addr == `NBR_ADDR_FULL_RST)
                            && i_reg_req.wdata[`NBR_FULL_RST_BIT];
   // pin or full reset bit restart the load at any time
   wire        hard_rst   = !i_reset_pin_n || full_rst;
   wire        lbl_wr     = wr_ok && hit_lbl;
   wire        last_byte  = (idx_q == AW'(LABEL_BYTES - 1));

   // ==========================================================
   // bank store
   wire        nvm_wr_en = (state_q == nbr_pkg::NBR_BURN);
   wire [7:0]  nvm_rd_data;

   nbr_nvm_store #(
      .BYTES         (LABEL_BYTES),
      .AW            (AW),
      .FACTORY_IMAGE (FACTORY_IMAGE)
   ) u_store (
      .i_mclk    (i_mclk),
      .i_wr_en   (nvm_wr_en),
      .i_wr_bank (burned_q[0]),
      .i_wr_addr (idx_q),
      .i_wr_data (label_q[idx_q]),
      .i_rd_bank (burned_q),
      .i_rd_addr (idx_q),
      .o_rd_data (nvm_rd_data)
   );

   // ==========================================================
   // sequencer next state
   always_comb
   begin
      state_d    = state_q;
      idx_d      = idx_q;
      prog_cnt_d = prog_cnt_q;
      burned_d   = burned_q;
      active_d   = active_q;
      case (state_q)
         nbr_pkg::NBR_IDLE:
         begin
            idx_d = '0;
            if (burn_go)
            begin
               state_d = nbr_pkg::NBR_BURN;
            end
            else if (reload_cmd)
            begin
               state_d = nbr_pkg::NBR_LOAD;
            end
         end
         nbr_pkg::NBR_BURN:
         begin
            idx_d = idx_q + AW'(1);
            if (last_byte)
            begin
               state_d    = nbr_pkg::NBR_PROG;
               prog_cnt_d = CW'(PROG_CYCLES);
            end
         end
         nbr_pkg::NBR_PROG:
         begin
            // cell programming time before the bank is counted
            prog_cnt_d = prog_cnt_q - CW'(1);
            if (prog_cnt_q == CW'(1))
            begin
               state_d  = nbr_pkg::NBR_IDLE;
               burned_d = burned_q + 2'h1;
            end
         end
         nbr_pkg::NBR_LOAD:
         begin
            idx_d = idx_q + AW'(1);
            if (last_byte)
            begin
               state_d  = nbr_pkg::NBR_IDLE;
               active_d = burned_q;
            end
         end
         default:
         begin
            state_d = nbr_pkg::NBR_IDLE;
         end
      endcase
      if (hard_rst)
      begin
         // a hard reset during a burn abandons it; the bank is not counted unless the reset lands in the last programming cycle
         state_d = nbr_pkg::NBR_LOAD;
         idx_d   = '0;
      end
   end

   // ==========================================================
   // read data
   wire [7:0] ready_val = idle ? `NBR_READY_CODE : `NBR_BUSY_CODE;
   wire [7:0] bank_val  = (active_q == 2'h0) ? `NBR_BANK_FACTORY :
                          (active_q == 2'h1) ? `NBR_BANK_ONE : `NBR_BANK_TWO;

   always_comb
   begin
      if (hit_ready)
      begin
         rdata_d = ready_val;
      end
      else if (hit_bank)
      begin
         rdata_d = bank_val;
      end
      else if (hit_lbl)
      begin
         rdata_d = label_q[lbl_idx];
      end
      else
      begin
         rdata_d = `NBR_READ_ZERO;
      end
   end

   // ==========================================================
   // flops; power-on starts with a load from the factory bank
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_q    <= nbr_pkg::NBR_LOAD;
         idx_q      <= '0;
         prog_cnt_q <= '0;
         burned_q   <= 2'h0;
         active_q   <= 2'h0;
      end
      else
      begin
         state_q    <= state_d;
         idx_q      <= idx_d;
         prog_cnt_q <= prog_cnt_d;
         burned_q   <= burned_d;
         active_q   <= active_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_reg_rdata  <= `NBR_READ_ZERO;
         o_reg_rvalid <= 1'b0;
         o_busy       <= 1'b1;
      end
      else
      begin
         o_reg_rdata  <= i_reg_req.rd ? rdata_d : `NBR_READ_ZERO;
         o_reg_rvalid <= i_reg_req.rd;
         o_busy       <= (state_d != nbr_pkg::NBR_IDLE);
      end
   end

   // ==========================================================
   // live label bytes
   genvar g;
   generate
      for (g = 0; g < LABEL_BYTES; g++)
      begin : g_label
         always_ff @(posedge i_mclk or negedge i_rst_b)
         begin
            if (!i_rst_b)
            begin
               label_q[g] <= `NBR_READ_ZERO;
            end
            else if ((state_q == nbr_pkg::NBR_LOAD) && (idx_q == AW'(g)))
            begin
               label_q[g] <= nvm_rd_data;
            end
            else if (lbl_wr && (lbl_idx == AW'(g)))
            begin
               label_q[g] <= i_reg_req.wdata;
            end
         end
      end
   endgenerate

endmodule // nbr_sequencer

// ---- nbr_defs.svh ----
// constants of the nvm burn and reload sequencer
//
// Operation
// - indicator reads 3, 15, 63 by burns
// - code 0xC7 to burn register starts burn
// - ready reads 0x0F only when idle
// - ready readable at 0xFE on every page
// - reload bit 0 copies nvm into registers
// - any hard reset reloads newest nvm bank
// - indicator advances after burn and reload
// - eight label bytes are burned with image
// - 8-bit read-only indicator shows active bank
// - one factory bank, two user banks
// - full reset bit acts like reset pin
`ifndef NBR_DEFS_SVH
`define NBR_DEFS_SVH

// ==========================================================
// register addresses (page in upper byte)
`define NBR_ADDR_BANK      16'h00E2
`define NBR_ADDR_BURN      16'h00E3
`define NBR_ADDR_RELOAD    16'h00E4
`define NBR_ADDR_FULL_RST  16'h001E
`define NBR_ADDR_LBL_FIRST 16'h026B
`define NBR_ADDR_LBL_LAST  16'h0272
`define NBR_READY_OFFSET   8'hFE

// ==========================================================
// fields and codes
`define NBR_RELOAD_BIT     0
`define NBR_FULL_RST_BIT   1
`define NBR_BURN_KEY       8'hC7
`define NBR_READY_CODE     8'h0F
`define NBR_BUSY_CODE      8'h00
`define NBR_BANK_FACTORY   8'h03
`define NBR_BANK_ONE       8'h0F
`define NBR_BANK_TWO       8'h3F
`define NBR_USER_BANKS     2'h2
`define NBR_READ_ZERO      8'h00

`endif

// ---- nbr_pkg.sv ----
// types of the nvm burn and reload sequencer
package nbr_pkg;

   // ==========================================================
   // register access carried from the serial interface
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } nbr_reg_req_t;

   // ==========================================================
   // sequencer states
   typedef enum logic [1:0] {
      NBR_IDLE,
      NBR_BURN,
      NBR_PROG,
      NBR_LOAD
   } nbr_state_t;

endpackage

// ---- nbr_nvm_store.sv ----
// nonvolatile bank store: one factory bank, two user banks
`timescale 1ns/1ps
module nbr_nvm_store #(
   parameter int          BYTES         = 8,
   parameter int          AW            = 3,
   parameter logic [63:0] FACTORY_IMAGE = 64'h0000000000000000
) (
   input  wire logic          i_mclk,
   input  wire logic          i_wr_en,
   input  wire logic          i_wr_bank,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [7:0]    i_wr_data,
   input  wire logic [1:0]    i_rd_bank,
   input  wire logic [AW-1:0] i_rd_addr,
   output      logic [7:0]    o_rd_data
);

   // ==========================================================
   // user banks; no reset, the contents model stored cells
   logic [7:0] user_mem [2][BYTES];
   logic [7:0] factory_byte;

   // factory bank cannot be written, it is a constant image
   assign factory_byte = FACTORY_IMAGE[8*i_rd_addr +: 8];

   always_ff @(posedge i_mclk)
   begin
      if (i_wr_en)
      begin
         user_mem[i_wr_bank][i_wr_addr] <= i_wr_data;
      end
   end

   assign o_rd_data = (i_rd_bank == 2'h0) ? factory_byte : user_mem[i_rd_bank[1]][i_rd_addr];

endmodule // nbr_nvm_store

// ---- nbr_sequencer_asserts.sv ----
// port assertions for the burn and reload sequencer
`timescale 1ns/1ps
`include "nbr_defs.svh"
module nbr_sequencer_asserts #(
   parameter int LABEL_BYTES = 8,
   parameter int PROG_CYCLES = 64
) (
   input wire logic                  i_mclk,
   input wire logic                  i_rst_b,
   input wire logic                  i_reset_pin_n,
   input wire nbr_pkg::nbr_reg_req_t i_reg_req,
   input wire logic [7:0]            o_reg_rdata,
   input wire logic                  o_reg_rvalid,
   input wire logic                  o_busy
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // ==========
   // decode
   wire [15:0] ad   = i_reg_req.addr;
   wire        wr   = i_reg_req.wr && !o_busy;
   wire        rdy  = i_reg_req.rd && ad[7:0] == `NBR_READY_OFFSET;
   wire        key  = i_reg_req.wdata == `NBR_BURN_KEY;
   wire        burn = wr && ad == `NBR_ADDR_BURN;
   wire        ld   = wr && ad == `NBR_ADDR_RELOAD && i_reg_req.wdata[`NBR_RELOAD_BIT];
   wire        hard = wr && ad == `NBR_ADDR_FULL_RST && i_reg_req.wdata[`NBR_FULL_RST_BIT];
   // last indicator the host read: only then is a spent part known
   logic [7:0] bank_q;
   logic       seen_q;
   always_ff @(posedge i_mclk or negedge i_rst_b)
      if (!i_rst_b)
         {seen_q, bank_q} <= 9'h000;
      else
      begin
         seen_q <= i_reg_req.rd && ad == `NBR_ADDR_BANK;
         if (seen_q && o_reg_rvalid)
            bank_q <= o_reg_rdata;
      end
   // ==========
   // properties
   a_rd_answer: assert property (i_reg_req.rd |=> o_reg_rvalid) else $error("read unanswered");
   a_ready_idle: assert property (rdy && !o_busy ##1 !o_busy |-> o_reg_rdata == `NBR_READY_CODE)
      else $error("idle code wrong");
   a_ready_busy: assert property (rdy && o_busy ##1 o_busy |-> o_reg_rdata == `NBR_BUSY_CODE)
      else $error("busy code wrong");
   a_burn_start: assert property (burn && key && bank_q != `NBR_BANK_TWO |=> o_busy)
      else $error("burn lost");
   a_burn_spent: assert property (burn && bank_q == `NBR_BANK_TWO |=> !o_busy)
      else $error("spent burn");
   a_bad_key: assert property (burn && !key |=> !o_busy) else $error("bad key burned");
   // one busy cycle per label byte, then idle at once
   a_load_span: assert property (ld |=> o_busy[*8] ##1 !o_busy) else $error("load span");
   a_pin_reload: assert property (!i_reset_pin_n |=> o_busy) else $error("pin no reload");
   a_full_reset: assert property (hard |=> o_busy) else $error("full reset no reload");
   c_burn: cover property (burn && key ##1 o_busy);
   c_spent: cover property (burn && bank_q == `NBR_BANK_TWO);
   c_poll_busy: cover property (rdy && o_busy);
endmodule // nbr_sequencer_asserts
bind nbr_sequencer nbr_sequencer_asserts #(.LABEL_BYTES(LABEL_BYTES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
   .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reset_pin_n(i_reset_pin_n), .i_reg_req(i_reg_req),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_busy(o_busy));

// ---- nbr_host_model.sv ----
// host model issuing register accesses
`timescale 1ns/1ps
module nbr_host_model (
   input  wire logic                  i_mclk,
   input  wire logic [7:0]            i_reg_rdata,
   input  wire logic                  i_reg_rvalid,
   output      nbr_pkg::nbr_reg_req_t o_reg_req
);
   initial o_reg_req = '{wr: 1'b0, rd: 1'b0, addr: 16'hFFFF, wdata: 8'hFF};
   // ==========
   // bus cycles
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge i_mclk);
      // released lines show the inverse, never a stale value
      o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge i_mclk);
      o_reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
      @(posedge i_mclk);
      o_reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
      // the answer stands for the cycle after the request; take it at its edge
      @(posedge i_mclk);
      d = i_reg_rdata;
      v = i_reg_rvalid;
   endtask
   // nothing but the ready code is touched until idle
   task automatic poll_ready(input logic [7:0] pg, output logic ok);
      logic [7:0] d;
      logic       v;
      ok = 1'b0;
      for (int n = 0; n < 200 && !ok; n++)
      begin
         reg_rd({pg, 8'hFE}, d, v);
         ok = v === 1'b1 && d === 8'h0F;
      end
   endtask
endmodule // nbr_host_model

// ---- nbr_sequencer_tb_top.sv ----
// self-checking bench for the burn and reload sequencer
`timescale 1ns/1ps
module nbr_sequencer_tb_top;
   logic                  i_mclk = 1'b0;
   logic                  i_rst_b = 1'b0;
   logic                  pin_n = 1'b1;
   nbr_pkg::nbr_reg_req_t req;
   logic [7:0]            rdata;
   logic                  rvalid;
   logic                  busy;
   logic [7:0]            d;
   logic                  v;
   logic                  ok;
   int                    error_cnt = 0;
   int                    checks = 0;
   always #4 i_mclk = ~i_mclk;
   // short program time keeps polls brief
   nbr_sequencer #(.PROG_CYCLES(4)) DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_reset_pin_n(pin_n),
      .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_busy(busy));
   nbr_host_model host (.i_mclk(i_mclk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid), .o_reg_req(req));
   // ==========
   // checks
   task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic rd_chk(input string w, input logic [15:0] a, input logic [7:0] exp);
      host.reg_rd(a, d, v);
      chk(w, v === 1'b1 ? d : 8'hEE, exp);
   endtask
   task automatic settle(input logic [7:0] pg);
      host.poll_ready(pg, ok);
      chk("ready", {7'h00, ok}, 8'h01);
      chk("busy", {7'h00, busy}, 8'h00);
   endtask
   task automatic lbl_set(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         host.reg_wr(16'h026B + 16'(i), b + 8'(i));
   endtask
   task automatic lbl_chk(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         rd_chk("label", 16'h026B + 16'(i), b + 8'(i));
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========
   // tests
   initial
   begin
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      settle(8'h00);
      rd_chk("bank", 16'h00E2, 8'h03);
      host.reg_wr(16'h00E2, 8'h3F);
      rd_chk("bank ro", 16'h00E2, 8'h03);
      rd_chk("unmapped", 16'h0300, 8'h00);
      $display("test reset done");
      lbl_set(8'hA0);
      lbl_chk(8'hA0);
      host.reg_wr(16'h00E3, 8'h55);
      rd_chk("bad key", 16'h00FE, 8'h0F);
      host.reg_wr(16'h00E4, 8'h00);
      rd_chk("no reload", 16'h00FE, 8'h0F);
      host.reg_wr(16'h00E3, 8'hC7);
      rd_chk("burning", 16'h01FE, 8'h00);
      chk("busy on", {7'h00, busy}, 8'h01);
      settle(8'h02);
      rd_chk("bank pre", 16'h00E2, 8'h03);
      host.reg_wr(16'h026B, 8'h11);
      host.reg_wr(16'h00E4, 8'h01);
      rd_chk("loading", 16'h00FE, 8'h00);
      settle(8'h00);
      rd_chk("bank one", 16'h00E2, 8'h0F);
      lbl_chk(8'hA0);
      $display("test burn reload done");
      lbl_set(8'hB0);
      host.reg_wr(16'h00E3, 8'hC7);
      settle(8'h00);
      host.reg_wr(16'h026B, 8'h22);
      @(posedge i_mclk);
      pin_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      pin_n <= 1'b1;
      settle(8'h00);
      rd_chk("bank two", 16'h00E2, 8'h3F);
      lbl_chk(8'hB0);
      $display("test pin reload done");
      host.reg_wr(16'h026B, 8'h33);
      host.reg_wr(16'h00E3, 8'hC7);
      rd_chk("spent", 16'h00FE, 8'h0F);
      host.reg_wr(16'h001E, 8'h02);
      settle(8'h00);
      rd_chk("bank kept", 16'h00E2, 8'h3F);
      lbl_chk(8'hB0);
      $display("test spent part done");
      stop_test();
   end
   // the run needs about 250 cycles
   initial
   begin
      #30000;
      error_cnt++;
      stop_test();
   end
endmodule // nbr_sequencer_tb_top
